//--- src/aoc_pkg.sv
/*
  Shared constants and types for the converter output coding block.
  Assumes the sample difference arrives as a signed word in LSB units.
*/
package aoc_pkg;

    // Output word and sample widths
    localparam int AOC_CODE_W = 12;
    localparam int AOC_DIFF_W = 14;

    // Input span edges, in LSB units of the difference word
    localparam logic signed [AOC_DIFF_W-1:0] AOC_POS_FULL = 14'sh0800;
    localparam logic signed [AOC_DIFF_W-1:0] AOC_NEG_FULL = 14'sh3800;
    localparam logic signed [AOC_DIFF_W-1:0] AOC_POS_LAST = 14'sh07ff;
    localparam logic signed [AOC_DIFF_W-1:0] AOC_ZERO_IN  = 14'sh0000;

    // Output codes
    localparam logic [AOC_CODE_W-1:0] AOC_BIN_ZERO = 12'h000;
    localparam logic [AOC_CODE_W-1:0] AOC_BIN_MID  = 12'h800;
    localparam logic [AOC_CODE_W-1:0] AOC_BIN_FULL = 12'hfff;
    localparam logic [AOC_CODE_W-1:0] AOC_TWO_LOW  = 12'h800;
    localparam logic [AOC_CODE_W-1:0] AOC_TWO_HIGH = 12'h7ff;
    localparam logic [AOC_CODE_W-1:0] AOC_MSB_FLIP = 12'h800;

    // Pipeline and buffer sizes, in clock cycles and words, and checking counter width in bits
    localparam int AOC_PIPE_CYCLES = 7;
    localparam int AOC_FIFO_WORDS  = 4;
    localparam int AOC_CNT_W       = 8;

    // Values after reset
    localparam logic [AOC_CODE_W-1:0] AOC_RST_CODE = 12'h000;
    localparam logic                  AOC_RST_FLAG = 1'b0;
    localparam logic                  AOC_RST_OE   = 1'b0;

    typedef enum logic
    {
        AOC_FMT_BIN  = 1'b0,
        AOC_FMT_TWOS = 1'b1
    } aoc_fmt_e;

    typedef enum logic
    {
        AOC_OUT_IDLE = 1'b0,
        AOC_OUT_HOLD = 1'b1
    } aoc_out_e;

    typedef struct packed
    {
        logic                  flag;
        logic [AOC_CODE_W-1:0] code;
    } aoc_word_s;

endpackage

//--- src/aoc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module aoc_fifo
#(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
)
(
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;

    assign inReady  = (count != CW'(DEPTH));
    assign outValid = (count != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr];

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop)
            begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            count <= '0;
        end
        else if (push && !pop)
        begin
            count <= count + 1'b1;
        end
        else if (pop && !push)
        begin
            count <= count - 1'b1;
        end
    end

endmodule // aoc_fifo

//--- src/aoc_coder.sv
/*
  Maps one signed sample difference to a clamped output code and flag.
  Assumes the format input is already a steady, registered level.
*/
`timescale 1ns/1ps
module aoc_coder
    import aoc_pkg::*;
(
    input  wire logic signed [AOC_DIFF_W-1:0] sampleDiff,
    input  wire aoc_fmt_e                     format,
    output aoc_word_s                         word
);
    logic signed [AOC_DIFF_W-1:0] offset;
    logic        [AOC_CODE_W-1:0] binCode;
    logic                         under;
    logic                         over;

    assign under  = (sampleDiff < AOC_NEG_FULL);
    assign over   = (sampleDiff >= AOC_POS_FULL);
    assign offset = sampleDiff + AOC_POS_FULL;

    always_comb
    begin
        if (under)
        begin
            binCode = AOC_BIN_ZERO; // RQ1
        end
        else if (over)
        begin
            binCode = AOC_BIN_FULL; // RQ1
        end
        else
        begin
            binCode = offset[AOC_CODE_W-1:0]; // RQ1
        end
    end

    always_comb
    begin
        word.flag = under || over; // RQ4
        if (format == AOC_FMT_TWOS)
        begin
            word.code = binCode ^ AOC_MSB_FLIP; // RQ2
        end
        else
        begin
            word.code = binCode;
        end
    end

endmodule // aoc_coder

//--- src/aoc_top.sv
/*
  Output side of a pipelined 12-bit converter: coding, range flag,
  fixed-latency pipeline, 4-word buffer and a three-state data port.
  Assumes samples and pins are synchronous to core_clk.
*/
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Binary: clamp low zeros, mid top, ones
// [RQ2] Twos complement: top bit flipped binary code
// [RQ3] Flag travels with its own data word
// [RQ4] Flag high only outside input span
// [RQ5] Flag holds until in-range word output
// [RQ6] Capture decodes range from flag, top bit
// [RQ7] Enable low drives data, high releases
// [RQ8] Enable only for slow, occasional switching
// [RQ9] Strapped select chooses binary or twos
// [RQ10] Samples taken on clock rising edge
// [RQ11] One word per cycle, fixed latency
module aoc_top
    import aoc_pkg::*;
#(
    parameter int PIPE_DEPTH = AOC_PIPE_CYCLES,
    parameter int FIFO_DEPTH = AOC_FIFO_WORDS
)
(
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic                         coding_format_select,
    input  wire logic                         output_drive_enable_n,
    input  wire logic                         sampleValid,
    output logic                              sampleReady,
    input  wire logic signed [AOC_DIFF_W-1:0] sampleDiff,
    output logic             [AOC_CODE_W-1:0] dataOut,
    output logic                              dataOe,
    output logic                              range_exceeded_flag,
    output logic                              outValid,
    input  wire logic                         captureReady
);
    localparam int WORD_W = $bits(aoc_word_s);

    aoc_fmt_e  formatSel;
    aoc_word_s coded;
    aoc_word_s pipeWord  [PIPE_DEPTH+1];
    logic      pipeValid [PIPE_DEPTH+1];
    logic      advance;
    logic      fifoOutValid;
    logic      popReady;
    aoc_word_s fifoHead;
    aoc_out_e  outState;
    aoc_out_e  next_outState;

    // Strap is caught while reset is held and frozen afterwards
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            formatSel <= aoc_fmt_e'(coding_format_select); // RQ9
        end
    end

    aoc_coder u_coder
    (
        .sampleDiff (sampleDiff),
        .format     (formatSel),
        .word       (coded)
    );

    assign pipeWord[0]  = coded;
    assign pipeValid[0] = sampleValid;
    assign sampleReady  = advance;

    // Whole pipe moves as one, so latency is fixed in moving cycles
    for (genvar i = 0; i < PIPE_DEPTH; i++)
    begin : g_pipe
        always_ff @(posedge core_clk) // RQ10
        begin
            if (!rstn)
            begin
                pipeValid[i+1] <= 1'b0;
                pipeWord[i+1]  <= '0;
            end
            else if (advance)
            begin
                pipeValid[i+1] <= pipeValid[i];
                pipeWord[i+1]  <= pipeWord[i]; // RQ3
            end
        end
    end

    aoc_fifo
    #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .core_clk (core_clk),
        .rstn     (rstn),
        .inValid  (pipeValid[PIPE_DEPTH]),
        .inReady  (advance),
        .inData   (pipeWord[PIPE_DEPTH]),
        .outValid (fifoOutValid),
        .outReady (popReady),
        .outData  (fifoHead)
    );

    // Output holding register
    assign popReady = (outState == AOC_OUT_IDLE) || captureReady;
    assign outValid = (outState == AOC_OUT_HOLD);

    always_comb
    begin
        next_outState = outState;
        case (outState)
            AOC_OUT_IDLE:
            begin
                if (fifoOutValid)
                begin
                    next_outState = AOC_OUT_HOLD;
                end
            end
            AOC_OUT_HOLD:
            begin
                if (captureReady && !fifoOutValid)
                begin
                    next_outState = AOC_OUT_IDLE;
                end
            end
            default:
            begin
                next_outState = AOC_OUT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            outState <= AOC_OUT_IDLE;
        end
        else
        begin
            outState <= next_outState; // RQ11
        end
    end

    // Word and flag load together and only on a new word
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dataOut             <= AOC_RST_CODE;
            range_exceeded_flag <= AOC_RST_FLAG;
        end
        else if (popReady && fifoOutValid)
        begin
            dataOut             <= fifoHead.code; // RQ3
            range_exceeded_flag <= fifoHead.flag; // RQ5
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dataOe <= AOC_RST_OE;
        end
        else
        begin
            dataOe <= !output_drive_enable_n; // RQ7
        end
    end

    // Checking helpers
    logic [AOC_CNT_W-1:0] advCount;
    logic                 loadOut;

    assign loadOut = popReady && fifoOutValid;

    always_ff @(posedge core_clk)
    begin
        if (!rstn || !advance)
        begin
            advCount <= '0;
        end
        else if (advCount < AOC_CNT_W'(PIPE_DEPTH))
        begin
            advCount <= advCount + 1'b1;
        end
    end

    // Words accepted but not yet taken by the capture side
    logic [AOC_CNT_W-1:0] inFlight;
    logic                 takeIn;
    logic                 takeOut;

    assign takeIn  = sampleValid && advance;
    assign takeOut = outValid && captureReady;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            inFlight <= '0;
        end
        else if (takeIn && !takeOut)
        begin
            inFlight <= inFlight + 1'b1;
        end
        else if (takeOut && !takeIn)
        begin
            inFlight <= inFlight - 1'b1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_bin_under: assert property ( // RQ1
        formatSel == AOC_FMT_BIN && sampleDiff < AOC_NEG_FULL
        |-> coded.code == AOC_BIN_ZERO && coded.flag)
        else $error("binary underrange code wrong");

    a_bin_points: assert property ( // RQ1
        formatSel == AOC_FMT_BIN && (sampleDiff == AOC_ZERO_IN
        || sampleDiff >= AOC_POS_LAST)
        |-> coded.code == ((sampleDiff == AOC_ZERO_IN)
            ? AOC_BIN_MID : AOC_BIN_FULL))
        else $error("binary mid or top code wrong");

    a_twos_points: assert property ( // RQ2
        formatSel == AOC_FMT_TWOS && (sampleDiff <= AOC_NEG_FULL
        || sampleDiff >= AOC_POS_LAST || sampleDiff == AOC_ZERO_IN)
        |-> coded.code == ((sampleDiff <= AOC_NEG_FULL) ? AOC_TWO_LOW
            : (sampleDiff == AOC_ZERO_IN) ? AOC_BIN_ZERO
            : AOC_TWO_HIGH))
        else $error("twos complement extreme code wrong");

    a_flag_span: assert property ( // RQ4
        coded.flag == (sampleDiff < AOC_NEG_FULL
            || sampleDiff >= AOC_POS_FULL))
        else $error("range flag disagrees with span");

    a_pipe_latency: assert property ( // RQ3
        advCount == AOC_CNT_W'(PIPE_DEPTH)
        |-> pipeWord[PIPE_DEPTH] == $past(pipeWord[0], PIPE_DEPTH)
            && pipeValid[PIPE_DEPTH] == $past(pipeValid[0], PIPE_DEPTH))
        else $error("word or flag latency wrong");

    a_flag_hold: assert property ( // RQ5
        !loadOut |=> $stable(range_exceeded_flag) && $stable(dataOut))
        else $error("flag changed without a new word");

    a_flag_load: assert property ( // RQ5
        loadOut |=> range_exceeded_flag == $past(fifoHead.flag)
            && dataOut == $past(fifoHead.code))
        else $error("output word not loaded with its flag");

    a_oe_drive: assert property ( // RQ7
        !output_drive_enable_n ##1 !output_drive_enable_n |-> dataOe)
        else $error("data not driven while enabled");

    a_oe_release: assert property ( // RQ7
        output_drive_enable_n |=> !dataOe)
        else $error("data driven while disabled");

    a_format_static: assert property ( // RQ9
        $past(rstn) |-> $stable(formatSel))
        else $error("format select changed after reset");

    a_out_stall: assert property ( // RQ11
        outValid && !captureReady |=> outValid && $stable(dataOut))
        else $error("held word lost under stall");

    a_out_stream: assert property ( // RQ11
        outValid && captureReady && fifoOutValid |=> outValid)
        else $error("stream gap with words waiting");

    a_flight_bound: assert property ( // RQ11
        inFlight <= AOC_CNT_W'(PIPE_DEPTH + FIFO_DEPTH + 1))
        else $error("more words in flight than storage");

    a_ready_full: assert property ( // RQ11
        !advance |-> fifoOutValid && outValid)
        else $error("input refused with room left");

    a_out_backed: assert property ( // RQ3
        outValid |-> inFlight != '0)
        else $error("word shown that was never accepted");

    c_overrange: cover property (
        loadOut && fifoHead.flag && fifoHead.code[AOC_CODE_W-1]);

    c_underrange: cover property (
        loadOut && fifoHead.flag && !fifoHead.code[AOC_CODE_W-1]);

    c_twos_mode: cover property (
        formatSel == AOC_FMT_TWOS && loadOut);

    c_backpressure: cover property (
        !advance && sampleValid ##1 advance);

    c_flag_clear: cover property (
        $fell(range_exceeded_flag));

endmodule // aoc_top

//--- tb/aoc_capture.sv
/*
  Capture-side model: takes output words and decodes range status.
  Assumes the block's output handshake and a steady format strap.
*/
`timescale 1ns/1ps
module aoc_capture
    import aoc_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic                  stall,
    input  wire logic                  fmt,
    input  wire logic [AOC_CODE_W-1:0] dataOut,
    input  wire logic                  flag,
    input  wire logic                  outValid,
    input  wire logic                  oe,
    output logic                       captureReady,
    output logic                       took,
    output aoc_word_s                  tookWord,
    output logic      [1:0]            rangeState
);
    logic                  topBit;
    logic [AOC_CODE_W-1:0] pinData;

    assign captureReady = !stall;
    // A released data bus reads back as the inverse of the last word
    assign pinData      = oe ? dataOut : ~dataOut;
    assign topBit       = pinData[AOC_CODE_W-1] ^ fmt;

    // Words are latched on the rising edge only
    always_ff @(posedge core_clk)
    begin
        took       <= rstn && outValid && captureReady;
        tookWord   <= '{flag: flag, code: pinData};
        // Flag low is in range; otherwise top bit tells under from over
        rangeState <= !flag ? 2'h0 : (topBit ? 2'h2 : 2'h1);
    end
endmodule // aoc_capture

//--- tb/testbench.sv
/*
  Self-checking bench for the converter output block.
  Assumes the capture model in aoc_capture and a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench
    import aoc_pkg::*;
;
    localparam int PIPE = 7;

    logic                         core_clk;
    logic                         rstn;
    logic                         fmtSel;
    logic                         enableN;
    logic                         sampleValid;
    logic signed [AOC_DIFF_W-1:0] sampleDiff;
    logic                         stall;
    logic                         sampleReady;
    logic        [AOC_CODE_W-1:0] dataOut;
    logic                         dataOe;
    logic                         rangeFlag;
    logic                         outValid;
    logic                         captureReady;
    logic                         took;
    aoc_word_s                    tookWord;
    logic        [1:0]            rangeState;
    int                           miscompares;
    int                           testsRun;
    aoc_word_s                    expQ[$];
    aoc_word_s                    capQ[$];
    logic        [1:0]            expSt[$];
    logic        [1:0]            stQ[$];

    aoc_top #(.PIPE_DEPTH(PIPE), .FIFO_DEPTH(AOC_FIFO_WORDS)) DUT
    (
        .core_clk(core_clk), .rstn(rstn),
        .coding_format_select(fmtSel), .output_drive_enable_n(enableN),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleDiff(sampleDiff), .dataOut(dataOut), .dataOe(dataOe),
        .range_exceeded_flag(rangeFlag), .outValid(outValid),
        .captureReady(captureReady)
    );

    aoc_capture CAP
    (
        .core_clk(core_clk), .rstn(rstn), .stall(stall), .fmt(fmtSel),
        .dataOut(dataOut), .flag(rangeFlag), .outValid(outValid),
        .captureReady(captureReady), .took(took), .tookWord(tookWord),
        .rangeState(rangeState), .oe(dataOe)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
    begin
        if (took === 1'b1)
        begin
            capQ.push_back(tookWord);
            stQ.push_back(rangeState);
        end
    end

    task automatic chk(input string what, input logic [12:0] exp,
                       input logic [12:0] got);
        testsRun++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finishTest();
        $display("Checks run %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic timeout(input string what);
        miscompares++;
        $display("[FAIL] %s expected done seen timeout", what);
        finishTest();
    endtask

    function automatic aoc_word_s expWord(input int d, input logic f);
        aoc_word_s w;
        w.flag = (d < -2048) || (d > 2047);
        w.code = d < -2048 ? AOC_BIN_ZERO :
                 d > 2047  ? AOC_BIN_FULL : 12'(d + 2048);
        if (f)
            w.code = w.code ^ AOC_MSB_FLIP;
        return w;
    endfunction

    task automatic doReset(input logic f);
        rstn   = 1'b0;
        fmtSel = f;
        repeat (6) @(posedge core_clk);
        #1 rstn = 1'b1;
        chk("idle outputs", 13'h002,
            {9'h0, outValid, dataOe, sampleReady, rangeFlag});
    endtask

    task automatic send(input int d);
        int  n;
        logic r;
        sampleValid = 1'b1;
        sampleDiff  = d[AOC_DIFF_W-1:0];
        for (n = 0; n < 50; n++)
        begin
            @(negedge core_clk) r = sampleReady;
            @(posedge core_clk) #1;
            if (r === 1'b1)
                break;
        end
        if (n == 50)
            timeout("sample accept");
        expQ.push_back(expWord(d, fmtSel));
        expSt.push_back(d < -2048 ? 2'h1 : (d > 2047 ? 2'h2 : 2'h0));
    endtask

    task automatic drain();
        int n;
        sampleValid = 1'b0;
        for (n = 0; n < 200 && capQ.size() < expQ.size(); n++)
            @(posedge core_clk) #1;
        if (capQ.size() < expQ.size())
            timeout("drain");
        foreach (expQ[i])
        begin
            chk("word", expQ[i], capQ[i]);
            chk("range state", {11'h0, expSt[i]}, {11'h0, stQ[i]});
        end
        expQ.delete();
        capQ.delete();
        expSt.delete();
        stQ.delete();
    endtask

    task automatic scenCodes(input logic f);
        int diffs[11] = '{-8192, -2049, -2048, 0, 2047, 2048, 8191, 5,
                          -2049, -2049, 100};
        doReset(f);
        foreach (diffs[i])
            send(diffs[i]);
        drain();
    endtask

    task automatic scenLatency();
        int n;
        send(0);
        sampleValid = 1'b0;
        for (n = 0; n < 20 && outValid !== 1'b1; n++)
            @(posedge core_clk) #1;
        chk("latency", 13'(PIPE + 1), 13'(n));
        drain();
    endtask

    task automatic scenEnable();
        chk("drive on", 13'h1, {12'h0, dataOe});
        enableN = 1'b1;
        @(posedge core_clk) #1;
        chk("drive off", 13'h0, {12'h0, dataOe});
        // Held for many cycles: the enable is for slow use only
        repeat (20) @(posedge core_clk);
        #1 enableN = 1'b0;
        @(posedge core_clk) #1;
        chk("drive on again", 13'h1, {12'h0, dataOe});
    endtask

    task automatic scenBackPressure();
        int   acc;
        logic r;
        acc         = 0;
        stall       = 1'b1;
        sampleValid = 1'b1;
        // A refused sample is held until it is taken
        for (int i = 0; i < 30; i++)
        begin
            sampleDiff = 14'(acc * 100 - 1500);
            @(negedge core_clk) r = sampleReady;
            @(posedge core_clk) #1;
            if (r === 1'b1)
            begin
                expQ.push_back(expWord(acc * 100 - 1500, fmtSel));
                expSt.push_back(2'h0);
                acc++;
            end
        end
        chk("stall fill", 13'(PIPE + AOC_FIFO_WORDS + 1), 13'(acc));
        stall = 1'b0;
        send(acc * 100 - 1500);
        drain();
    endtask

    initial
    begin
        miscompares = 0;
        testsRun    = 0;
        enableN     = 1'b0;
        sampleValid = 1'b0;
        sampleDiff  = '0;
        stall       = 1'b0;
        scenCodes(1'b0);
        scenLatency();
        scenEnable();
        scenBackPressure();
        scenCodes(1'b1);
        finishTest();
    end
endmodule // testbench
